// ### hdl/dsc_debug_support.v
/*
 * Debug-support register block: identity, low-power debug configuration
 * and two peripheral freeze registers on an Avalon-MM slave port.
 * Assumes resetn is power-on reset; system reset arrives separately and
 * leaves these registers alone. Bus inputs are synchronous to ref_clk.
 */
// The implementer's own choice: the Avalon-MM slave port.
// How it works
// - Identity read-only: device ID, revision fields
// - Only full 32-bit word accesses accepted
// - Four consecutive word registers decoded from base
// - Configuration cleared by power-on reset only
// - Host writes configuration during system reset
// - Stop without debug bit: clocks off, RC
// - Stop with debug bit: core clocks on RC
// - Standby without bit: power off, reset-like exit
// - Standby with bit: powered, exit via reset
// - Freeze bit halts counter while core halted
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defs.vh"

module dsc_debug_support #(
  parameter [11:0] DEVICE_ID   = 12'h123,   // Arbitrary value
  parameter [15:0] REVISION_ID = 16'h0001   // Arbitrary value
) (
  input  wire        ref_clk,              // 10 MHz system clock
  input  wire        resetn,               // Power-on reset, active low
  input  wire        sys_resetn,           // System reset, active low
  input  wire [31:0] avs_address,          // Byte address
  input  wire        avs_read,             // Read request
  input  wire        avs_write,            // Write request
  input  wire [31:0] avs_writedata,        // Write data
  input  wire [3:0]  avs_byteenable,       // Byte lanes
  output reg  [31:0] avs_readdata,         // Read data
  output reg         avs_waitrequest,      // Stall request
  output reg  [1:0]  avs_response,         // 00 okay, 10 slave error
  input  wire        core_halted,          // Core halted by debugger
  input  wire        stop_mode,            // Stop mode active
  input  wire        standby_mode,         // Standby mode active
  output reg  [31:0] low_freeze_r,         // Freeze enables, low bus peripherals
  output reg  [31:0] high_freeze_r,        // Freeze enables, high bus peripherals
  output wire        core_clk_en,          // Core and bus clocks enabled
  output wire        other_clk_en,         // Other clocks enabled
  output wire        rc_osc_en,            // Internal RC oscillator enabled
  output wire        digital_pwr,          // Digital logic powered
  output wire        clk_to_rc,            // Clock source forced to RC
  output wire        wake_reset            // Reset pulse on standby exit
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [31:0] cfg_r;
  reg [31:0] low_en_r;
  reg [31:0] high_en_r;
  reg        busy_r;

  wire [31:0] identity_val;

  localparam [31:0] BLOCK_BASE = `DSC_BASE_ADDR;

  function hit;
    input [31:0] addr;
    begin
      hit = (addr[31:4] == BLOCK_BASE[31:4]) && (addr[1:0] == 2'h0);
    end
  endfunction

  function [31:0] mask_of;
    input [1:0] idx;
    begin
      case (idx)
        `DSC_IDX_CONFIG:      mask_of = `DSC_CFG_MASK;
        `DSC_IDX_LOW_FREEZE:  mask_of = `DSC_LOW_MASK;
        `DSC_IDX_HIGH_FREEZE: mask_of = `DSC_HIGH_MASK;
        default:              mask_of = 32'h00000000;
      endcase
    end
  endfunction

  assign identity_val = {REVISION_ID, 4'h0, DEVICE_ID};

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire       req      = avs_read | avs_write;
  wire [1:0] idx      = avs_address[3:2];
  wire       full     = (avs_byteenable == 4'hF);
  wire       ok       = hit(avs_address) & full;
  wire       wr_ok    = avs_write & ok & (idx != `DSC_IDX_IDENTITY);
  wire       accept   = req & ~busy_r;

  reg [31:0] rd_nxt;

  always @* begin
    rd_nxt = `DSC_BAD_READ;
    if (ok) begin
      case (idx)
        `DSC_IDX_IDENTITY:    rd_nxt = identity_val;
        `DSC_IDX_CONFIG:      rd_nxt = cfg_r & `DSC_CFG_MASK;
        `DSC_IDX_LOW_FREEZE:  rd_nxt = low_en_r & `DSC_LOW_MASK;
        `DSC_IDX_HIGH_FREEZE: rd_nxt = high_en_r & `DSC_HIGH_MASK;
        default:              rd_nxt = `DSC_BAD_READ;
      endcase
    end
  end

  // One wait state: waitrequest drops in the cycle after a request is seen,
  // so the registered answer lines up with the master's sampling edge.
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy_r          <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
      avs_response    <= 2'h0;
    end else begin
      busy_r          <= accept;
      avs_waitrequest <= ~accept;
      if (accept) begin
        avs_readdata <= avs_read ? rd_nxt : 32'h00000000;
        avs_response <= ok ? 2'h0 : 2'h2;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers
  // Only resetn clears these; sys_resetn is deliberately not used so the
  // host can set up debug across a system reset.

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_r     <= `DSC_CFG_RESET;
      low_en_r  <= `DSC_FREEZE_RESET;
      high_en_r <= `DSC_FREEZE_RESET;
    end else if (accept & wr_ok) begin
      case (idx)
        `DSC_IDX_CONFIG:      cfg_r     <= avs_writedata & mask_of(idx);
        `DSC_IDX_LOW_FREEZE:  low_en_r  <= avs_writedata & mask_of(idx);
        `DSC_IDX_HIGH_FREEZE: high_en_r <= avs_writedata & mask_of(idx);
        default:              cfg_r     <= cfg_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Freeze outputs: enable bits gated by the halt state

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      low_freeze_r  <= 32'h00000000;
      high_freeze_r <= 32'h00000000;
    end else begin
      low_freeze_r  <= core_halted ? low_en_r : 32'h00000000;
      high_freeze_r <= core_halted ? high_en_r : 32'h00000000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power steering

  dsc_low_power_ctrl u_lp (
    .ref_clk        (ref_clk),
    .resetn         (resetn),
    .stop_mode      (stop_mode),
    .standby_mode   (standby_mode),
    .stop_dbg       (cfg_r[`DSC_CFG_STOP_BIT]),
    .standby_dbg    (cfg_r[`DSC_CFG_STANDBY_BIT]),
    .core_clk_en_r  (core_clk_en),
    .other_clk_en_r (other_clk_en),
    .rc_osc_en_r    (rc_osc_en),
    .digital_pwr_r  (digital_pwr),
    .clk_to_rc_r    (clk_to_rc),
    .sys_reset_r    (wake_reset)
  );

endmodule
`default_nettype wire

// ### common/dsc_defs.vh
/*
 * Constants of the debug-support register block: offsets, field positions,
 * reset values and write masks.
 * Assumes inclusion by bare name from design files under hdl/.
 */
`ifndef DSC_DEFS_VH
`define DSC_DEFS_VH

// Byte addresses of the four word registers
`define DSC_BASE_ADDR        32'h40015800
`define DSC_OFF_IDENTITY     32'h40015800
`define DSC_OFF_CONFIG       32'h40015804
`define DSC_OFF_LOW_FREEZE   32'h40015808
`define DSC_OFF_HIGH_FREEZE  32'h4001580C

// Word index within the block, taken from address bits 3:2
`define DSC_IDX_IDENTITY     2'h0
`define DSC_IDX_CONFIG       2'h1
`define DSC_IDX_LOW_FREEZE   2'h2
`define DSC_IDX_HIGH_FREEZE  2'h3

// Identity register fields
`define DSC_ID_DEV_LSB       0
`define DSC_ID_DEV_MSB       11
`define DSC_ID_REV_LSB       16
`define DSC_ID_REV_MSB       31

// Configuration register fields
`define DSC_CFG_STOP_BIT     1
`define DSC_CFG_STANDBY_BIT  2
`define DSC_CFG_MASK         32'h00000006
`define DSC_CFG_RESET        32'h00000000

// Freeze register writable bits and reset values
`define DSC_LOW_MASK         32'h00203D32
`define DSC_HIGH_MASK        32'h00070800
`define DSC_FREEZE_RESET     32'h00000000

// Answer to an unmapped or sub-word access
`define DSC_BAD_READ         32'h00000000

// Bus answer latency in cycles once a request is accepted
`define DSC_WAIT_CYCLES      1

`endif

// ### hdl/dsc_low_power_ctrl.v
/*
 * Low-power clock and power steering from the configuration bits.
 * Assumes stop and standby requests are levels from the power controller,
 * synchronous to ref_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dsc_defs.vh"

module dsc_low_power_ctrl (
  input  wire        ref_clk,        // System clock
  input  wire        resetn,         // Power-on reset, active low
  input  wire        stop_mode,      // Device is in stop mode
  input  wire        standby_mode,   // Device is in standby mode
  input  wire        stop_dbg,       // Stop-mode debug bit
  input  wire        standby_dbg,    // Standby debug bit
  output reg         core_clk_en_r,  // Core and bus clocks enabled
  output reg         other_clk_en_r, // Peripheral and other clocks enabled
  output reg         rc_osc_en_r,    // Internal RC oscillator enabled
  output reg         digital_pwr_r,  // Digital logic powered
  output reg         clk_to_rc_r,    // Clock source forced to internal RC
  output reg         sys_reset_r     // Wake reset pulse on standby exit
);

  reg standby_d_r;
  reg core_nxt;
  reg other_nxt;
  reg rc_nxt;
  reg pwr_nxt;
  reg rc_sel_nxt;

  always @* begin
    core_nxt   = 1'b1;
    other_nxt  = 1'b1;
    rc_nxt     = 1'b1;
    pwr_nxt    = 1'b1;
    rc_sel_nxt = clk_to_rc_r;
    if (standby_mode) begin
      core_nxt   = standby_dbg;
      other_nxt  = 1'b0;
      rc_nxt     = standby_dbg;
      pwr_nxt    = standby_dbg;
      rc_sel_nxt = 1'b1;
    end else if (stop_mode) begin
      core_nxt   = stop_dbg;
      other_nxt  = 1'b0;
      rc_nxt     = stop_dbg;
      rc_sel_nxt = 1'b1;
    end
  end

  // The RC source stays selected after wake; the other clocks and power come back on by themselves
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      core_clk_en_r  <= 1'b1;
      other_clk_en_r <= 1'b1;
      rc_osc_en_r    <= 1'b1;
      digital_pwr_r  <= 1'b1;
      clk_to_rc_r    <= 1'b1;
      sys_reset_r    <= 1'b0;
      standby_d_r    <= 1'b0;
    end else begin
      core_clk_en_r  <= core_nxt;
      other_clk_en_r <= other_nxt;
      rc_osc_en_r    <= rc_nxt;
      digital_pwr_r  <= pwr_nxt;
      clk_to_rc_r    <= rc_sel_nxt;
      standby_d_r    <= standby_mode;
      sys_reset_r    <= standby_d_r & ~standby_mode;
    end
  end

endmodule
`default_nettype wire

// ### verification/dsc_checker.sv
/* Port checker for the debug-support block.
   Assumes a bind onto dsc_debug_support and one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module dsc_checker (
  input wire        ref_clk,         // Clock
  input wire        resetn,          // Power-on reset
  input wire [31:0] avs_address,     // Address
  input wire        avs_read,        // Read
  input wire        avs_write,       // Write
  input wire [3:0]  avs_byteenable,  // Lanes
  input wire [31:0] avs_readdata,    // Read data
  input wire        avs_waitrequest, // Stall
  input wire [1:0]  avs_response,    // Response
  input wire        core_halted,     // Halted
  input wire        stop_mode,       // Stop
  input wire        standby_mode,    // Standby
  input wire [31:0] low_freeze_r,    // Freeze out
  input wire        other_clk_en,    // Other clocks
  input wire        rc_osc_en,       // RC on
  input wire        core_clk_en,     // Core clocks
  input wire        digital_pwr,     // Power
  input wire        wake_reset       // Wake pulse
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence ans_s; $fell(avs_waitrequest); endsequence
  sequence req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
  ////////////////////////////////////////////////////////////
  wait_answer_a: assert property (req_s |-> ##[1:2] !avs_waitrequest)
    else $error("no answer");
  wait_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("long answer");
  lane_refuse_a: assert property (ans_s and $past(avs_byteenable) != 4'hF |-> avs_response == 2'h2)
    else $error("subword accepted");
  id_readonly_a: assert property (ans_s and $past(avs_write) && $past(avs_address) == 32'h40015800
    && $past(avs_byteenable) == 4'hF |-> avs_response == 2'h0 && avs_readdata == 32'h0)
    else $error("id write taken");
  unmapped_err_a: assert property (ans_s and $past(avs_address[31:4]) != 28'h4001580
    |-> avs_response == 2'h2 && avs_readdata == 32'h0)
    else $error("unmapped answered");
  cfg_reserved_a: assert property (ans_s and $past(avs_read) && $past(avs_address) == 32'h40015804
    |-> (avs_readdata & 32'hFFFFFFF9) == 32'h0)
    else $error("reserved bits set");
  freeze_run_a: assert property (!$past(core_halted) |-> low_freeze_r == 32'h0)
    else $error("freeze while running");
  other_off_a: assert property (stop_mode && $past(stop_mode) |-> !other_clk_en)
    else $error("other clocks on");
  stop_rc_a: assert property (stop_mode && $past(stop_mode) && core_clk_en |-> rc_osc_en)
    else $error("core without rc");
  wake_pulse_a: assert property ($fell(standby_mode) |-> ##[1:2] wake_reset)
    else $error("no wake reset");
endmodule
bind dsc_debug_support dsc_checker chk (.ref_clk, .resetn, .avs_address, .avs_read,
  .avs_write, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
  .core_halted, .stop_mode, .standby_mode, .low_freeze_r, .other_clk_en, .rc_osc_en,
  .core_clk_en, .digital_pwr, .wake_reset);
`default_nettype wire

// ### verification/dsc_host.sv
/* Debug host model: an Avalon-MM master issuing single word transfers.
   Assumes the bench calls xfer and reads rdata and resp afterwards. */
`timescale 1ns/1ps
`default_nettype none
module dsc_host (
  input  wire logic        ref_clk,         // Clock
  input  wire logic        avs_waitrequest, // Stall
  input  wire logic [31:0] avs_readdata,    // Read data
  input  wire logic [1:0]  avs_response,    // Response
  output logic      [31:0] avs_address,     // Address
  output logic             avs_read,        // Read
  output logic             avs_write,       // Write
  output logic      [31:0] avs_writedata,   // Write data
  output logic      [3:0]  avs_byteenable   // Lanes
);
  logic [31:0] rdata;
  logic [1:0]  resp;
  initial begin
    avs_address = 32'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  ////////////////////////////////////////////////////////////
  // Lanes other than 4'hF only when a refusal is wanted
  task xfer(input logic wr, input logic [31:0] a, d, input logic [3:0] be);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    rdata = avs_readdata;
    resp = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/debug_support_config_bench.sv
/* Register and low-power tests of the debug-support block.
   Assumes dsc_host as bus master; the bound checker watches timing. */
`timescale 1ns/1ps
`default_nettype none
module debug_support_config_bench;
  logic        ref_clk, resetn, sys_resetn, core_halted, stop_mode, standby_mode;
  wire  [31:0] avs_address, avs_writedata, avs_readdata, low_freeze_r, high_freeze_r;
  wire  [3:0]  avs_byteenable;
  wire  [1:0]  avs_response;
  wire         avs_read, avs_write, avs_waitrequest, core_clk_en, other_clk_en;
  wire         rc_osc_en, digital_pwr, clk_to_rc, wake_reset;
  int          mismatches, n_checks, cycles;
  dsc_debug_support dut (.ref_clk, .resetn, .sys_resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .avs_response, .core_halted, .stop_mode, .standby_mode, .low_freeze_r,
    .high_freeze_r, .core_clk_en, .other_clk_en, .rc_osc_en, .digital_pwr,
    .clk_to_rc, .wake_reset);
  dsc_host host (.ref_clk, .avs_waitrequest, .avs_readdata, .avs_response,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable);
  ////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task rd(input logic [31:0] a, exp, input logic [3:0] be, input logic [1:0] er);
    host.xfer(1'b0, a, 32'h0, be);
    check(host.rdata, exp);
    check({30'h0, host.resp}, {30'h0, er});
  endtask
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Generous ceiling; the sequence needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    {resetn, sys_resetn, core_halted, stop_mode, standby_mode} = 5'h08;
    tick(10);
    resetn <= 1'b1;
    rd(32'h40015800, 32'h00010123, 4'hF, 2'h0);
    host.xfer(1'b1, 32'h40015800, 32'hFFFFFFFF, 4'hF);
    rd(32'h40015800, 32'h00010123, 4'hF, 2'h0);
    rd(32'h40015804, 32'h0, 4'hF, 2'h0);
    sys_resetn <= 1'b0;
    host.xfer(1'b1, 32'h40015804, 32'hFFFFFFFF, 4'hF);
    sys_resetn <= 1'b1;
    rd(32'h40015804, 32'h6, 4'hF, 2'h0);
    rd(32'h40015810, 32'h0, 4'hF, 2'h2);
    rd(32'h40015804, 32'h0, 4'h3, 2'h2);
    host.xfer(1'b1, 32'h40015808, 32'hFFFFFFFF, 4'hF);
    host.xfer(1'b1, 32'h4001580C, 32'hFFFFFFFF, 4'hF);
    rd(32'h40015808, 32'h00203D32, 4'hF, 2'h0);
    core_halted <= 1'b1;
    tick(3);
    check(low_freeze_r, 32'h00203D32);
    check(high_freeze_r, 32'h00070800);
    core_halted <= 1'b0;
    tick(3);
    check(high_freeze_r, 32'h0);
    for (int i = 0; i < 4; i++) begin
      host.xfer(1'b1, 32'h40015804, i[1] ? (i[0] ? 32'h4 : 32'h2) : 32'h0, 4'hF);
      stop_mode <= !i[0];
      standby_mode <= i[0];
      tick(3);
      check({31'h0, core_clk_en}, {31'h0, i[1]});
      check({31'h0, i[0] ? digital_pwr : rc_osc_en}, {31'h0, i[1]});
      {stop_mode, standby_mode} <= 2'h0;
      tick(4);
      check({31'h0, clk_to_rc}, 32'h1);
    end
    sys_resetn <= 1'b0;
    tick(2);
    sys_resetn <= 1'b1;
    rd(32'h40015804, 32'h4, 4'hF, 2'h0);
    resetn <= 1'b0;
    tick(2);
    resetn <= 1'b1;
    rd(32'h40015804, 32'h0, 4'hF, 2'h0);
    rd(32'h40015808, 32'h0, 4'hF, 2'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
